//--- hw/down_timer_pwm_buzzer.sv
// Purpose: 10-bit down timer with prescaler, PWM and tone output on a Wishbone slave
// Assumes: CMP and external clock inputs synchronous to CLK_I
// Notes: Single-cycle ack; one-shot stops by clearing the count enable
// Function
// R1 - Ten-bit counter decrements on prescaled ticks
// R2 - Reload buffered, copied at underflow while running
// R3 - Disabled timer loads reload on low write
// R4 - Timer read returns live count
// R5 - Count only while enable bit set
// R6 - Source bit picks external pin or instruction clock
// R7 - Edge bit picks falling or rising external edge
// R8 - Active-low prescaler enable, ratio 1:2 to 1:256
// R9 - Prescaler count is readable
// R10 - One-shot counts down once then stops
// R11 - Free-run restarts from reload or 0x3FF
// R12 - Underflow sets flag; request when enabled globally; code also needs underflow_irq_enable_q
// R13 - Flag holds until firmware writes zero
// R14 - PWM enable drives shared pin as output
// R15 - Polarity bit selects active-low PWM
// R16 - Ten-bit duty; zero never active
// R17 - Firmware keeps duty not above reload
// R18 - Duty buffered, transferred at underflow
// R19 - Tone enable drives shared pin as output
// R20 - Tone source prescaler taps or timer bits
// R21 - Tone dividing rates 1:2 to 1:256
// R22 - Pin priority comparator, PWM, then tone
// R23 - Tone follows selected tap or bit
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`include "down_timer_cfg.svh"
module down_timer_pwm_buzzer
  import down_timer_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [5:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic EXT_COUNT_CLOCK_I,
  input wire logic CMP_OUT_I,
  input wire logic CMP_OUT_EN_I,
  output logic SHARED_OUTPUT_PIN_O,
  output logic SHARED_OUTPUT_PIN_OE_O,
  output logic TONE_OUTPUT_O,
  output logic IRQ_O
);
  byte_t timer_ctrl_one_q, timer_ctrl_two_q, tone_ctrl_reg_q;
  byte_t reload_duty_high_bits_q, reload_low_q, duty_low_q;
  count_t count_q, duty_act_q;
  byte_t prescaler_q;
  logic [7:0] instr_cnt_q;
  logic ext_prev_q, underflow_flag_q, underflow_irq_enable_q, global_irq_enable_q;
  logic pwm_q, tone_q, pin_q, pin_oe_q, ack_q;
  logic req, wr, instr_tick, ext_edge, src_tick, tick, uf, low_wr;
  logic [8:0] psc_next;
  logic [7:0] psc_mask;
  count_t reload_val, duty_val;
  pin_src_t pin_src;

  assign req = CYC_I && STB_I && !ack_q;
  assign wr = req && WE_I && SEL_I[0];
  assign low_wr = wr && ADR_I == `ADR_RELOAD_LOW;
  assign reload_val = {reload_duty_high_bits_q[5:4], reload_low_q};
  assign duty_val = {reload_duty_high_bits_q[1:0], duty_low_q};

  // Instruction clock enable from a divider
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      instr_cnt_q <= 8'h00;
    end else if (instr_cnt_q == `INSTR_DIV - 8'd1) begin
      instr_cnt_q <= 8'h00;
    end else begin
      instr_cnt_q <= instr_cnt_q + 8'd1;
    end
  end
  assign instr_tick = instr_cnt_q == `INSTR_DIV - 8'd1;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= EXT_COUNT_CLOCK_I;
    end
  end
  // R7 edge select
  assign ext_edge = timer_ctrl_two_q[`B_EDGE_SEL] ? (ext_prev_q && !EXT_COUNT_CLOCK_I)
                                                  : (!ext_prev_q && EXT_COUNT_CLOCK_I);
  // R6 source select
  assign src_tick = timer_ctrl_two_q[`B_SRC_SEL] ? ext_edge : instr_tick;

  // R8 prescaler tap, ratio 2^(sel+1)
  assign psc_next = {1'b0, prescaler_q} + 9'd1;
  always_comb begin
    if (timer_ctrl_two_q[`B_PSC_EN_N]) begin
      tick = src_tick;
    end else begin
      // Carry out of the selected bit: a plain toggle would divide by half as much
      tick = src_tick && prescaler_q[timer_ctrl_two_q[2:0]] && !psc_next[timer_ctrl_two_q[2:0]];
    end
  end

  // R9 prescaler count, readable
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prescaler_q <= 8'h00;
    end else if (src_tick && timer_ctrl_one_q[`B_COUNT_EN]) begin
      prescaler_q <= psc_next[7:0];
    end
  end

  // R5 run only when enabled
  assign uf = timer_ctrl_one_q[`B_COUNT_EN] && tick && count_q == 10'h000;

  // R1 down counter
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      count_q <= `TIMER_MAX;
    end else if (low_wr && !timer_ctrl_one_q[`B_COUNT_EN]) begin
      // R3 immediate load
      count_q <= {reload_duty_high_bits_q[5:4], DAT_I[7:0]};
    end else if (uf) begin
      // R11 restart value, R2 buffered reload
      count_q <= (timer_ctrl_one_q[`B_RELOAD_SEL] || timer_ctrl_one_q[`B_ONE_SHOT])
                 ? reload_val : `TIMER_MAX;
    end else if (timer_ctrl_one_q[`B_COUNT_EN] && tick) begin
      count_q <= count_q - 10'd1;
    end
  end

  // R18 duty transfer at underflow
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      duty_act_q <= 10'h000;
    end else if (uf || !timer_ctrl_one_q[`B_COUNT_EN]) begin
      duty_act_q <= duty_val;
    end
  end

  // Control registers; R10 one-shot clears enable at underflow
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      timer_ctrl_one_q <= `RST_CTRL_ONE;
      timer_ctrl_two_q <= `RST_CTRL_TWO;
      tone_ctrl_reg_q <= `RST_TONE_CTRL;
      reload_duty_high_bits_q <= 8'h00;
      reload_low_q <= 8'h00;
      duty_low_q <= 8'h00;
      underflow_irq_enable_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      if (wr) begin
        unique case (ADR_I)
          `ADR_CTRL_ONE: timer_ctrl_one_q <= DAT_I[7:0];
          `ADR_CTRL_TWO: timer_ctrl_two_q <= DAT_I[7:0];
          `ADR_HIGH_BITS: reload_duty_high_bits_q <= DAT_I[7:0];
          `ADR_RELOAD_LOW: reload_low_q <= DAT_I[7:0];
          `ADR_DUTY_LOW: duty_low_q <= DAT_I[7:0];
          `ADR_TONE_CTRL: tone_ctrl_reg_q <= DAT_I[7:0];
          `ADR_IRQ_ENABLE: underflow_irq_enable_q <= DAT_I[`B_UF_FLAG];
          `ADR_GLOBAL: global_irq_enable_q <= DAT_I[`B_GIE];
          default: ;
        endcase
      end
      // R10 one-shot stop
      if (uf && timer_ctrl_one_q[`B_ONE_SHOT]) begin
        timer_ctrl_one_q[`B_COUNT_EN] <= 1'b0;
      end
    end
  end

  // R12 R13 sticky flag, set wins over clear
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      underflow_flag_q <= 1'b0;
    end else if (uf) begin
      underflow_flag_q <= 1'b1;
    end else if (wr && ADR_I == `ADR_IRQ_FLAG && !DAT_I[`B_UF_FLAG]) begin
      underflow_flag_q <= 1'b0;
    end
  end
  // R12 interrupt request
  assign IRQ_O = underflow_flag_q && underflow_irq_enable_q && global_irq_enable_q;

  // R15 R16 PWM active while count below duty
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (count_q < duty_act_q) ^ timer_ctrl_one_q[`B_PWM_AL];
    end
  end

  // R20 R21 R23 tone source
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tone_q <= 1'b0;
    end else if (tone_ctrl_reg_q[`B_TONE_SRC]) begin
      tone_q <= count_q[tone_ctrl_reg_q[2:0]];
    end else begin
      tone_q <= prescaler_q[tone_ctrl_reg_q[2:0]];
    end
  end
  assign TONE_OUTPUT_O = tone_q;

  // R22 pin priority, R14 R19 force output
  always_comb begin
    if (CMP_OUT_EN_I) begin
      pin_src = PIN_COMP;
    end else if (timer_ctrl_one_q[`B_PWM_OEN]) begin
      pin_src = PIN_PWM;
    end else if (tone_ctrl_reg_q[`B_TONE_EN]) begin
      pin_src = PIN_TONE;
    end else begin
      pin_src = PIN_NONE;
    end
  end
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      unique case (pin_src)
        PIN_COMP: pin_q <= CMP_OUT_I;
        PIN_PWM: pin_q <= pwm_q;
        PIN_TONE: pin_q <= tone_q;
        PIN_NONE: pin_q <= 1'b0;
      endcase
      pin_oe_q <= pin_src != PIN_NONE;
    end
  end
  assign SHARED_OUTPUT_PIN_O = pin_q;
  assign SHARED_OUTPUT_PIN_OE_O = pin_oe_q;

  // R4 live count on read; bus answers one cycle after request
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        unique case (ADR_I)
          `ADR_CTRL_ONE: DAT_O <= {24'h0, timer_ctrl_one_q};
          `ADR_CTRL_TWO: DAT_O <= {24'h0, timer_ctrl_two_q};
          `ADR_HIGH_BITS: DAT_O <= {24'h0, 2'b00, count_q[9:8], 2'b00, duty_val[9:8]};
          `ADR_RELOAD_LOW: DAT_O <= {24'h0, count_q[7:0]};
          `ADR_DUTY_LOW: DAT_O <= {24'h0, duty_low_q};
          `ADR_TONE_CTRL: DAT_O <= {24'h0, tone_ctrl_reg_q};
          `ADR_PRESC_COUNT: DAT_O <= {24'h0, prescaler_q};
          `ADR_IRQ_FLAG: DAT_O <= {28'h0, underflow_flag_q, 3'b000};
          `ADR_IRQ_ENABLE: DAT_O <= {28'h0, underflow_irq_enable_q, 3'b000};
          `ADR_GLOBAL: DAT_O <= {31'h0, global_irq_enable_q};
          default: DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign ACK_O = ack_q;

  // R13 flag only falls after a write to the flag register
  flag_hold_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R13
    $fell(underflow_flag_q) |-> $past(wr) && $past(ADR_I) == `ADR_IRQ_FLAG)
    else $error("flag cleared without write");
  // R12 underflow sets flag
  flag_set_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R12
    uf |=> underflow_flag_q) else $error("flag not set");
  // R11 free-run restart value
  restart_val_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R11
    uf && !low_wr && !timer_ctrl_one_q[`B_RELOAD_SEL] && !timer_ctrl_one_q[`B_ONE_SHOT]
    |=> count_q == `TIMER_MAX) else $error("bad restart");
  // R10 one-shot stop
  one_shot_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R10
    uf && timer_ctrl_one_q[`B_ONE_SHOT] && !wr |=> !timer_ctrl_one_q[`B_COUNT_EN])
    else $error("one-shot kept running");
  // R5 hold when disabled
  hold_off_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R5
    !timer_ctrl_one_q[`B_COUNT_EN] && !low_wr |=> $stable(count_q))
    else $error("count moved while off");
  // R1 decrement by one
  dec_one_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R1
    timer_ctrl_one_q[`B_COUNT_EN] && tick && count_q != 10'h000 && !low_wr
    |=> count_q == $past(count_q) - 10'd1) else $error("bad decrement");
  // R3 immediate load
  load_off_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R3
    low_wr && !timer_ctrl_one_q[`B_COUNT_EN] |=> count_q[7:0] == $past(DAT_I[7:0]))
    else $error("no immediate load");
  // R22 comparator priority
  pin_prio_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R22
    CMP_OUT_EN_I |=> SHARED_OUTPUT_PIN_OE_O && SHARED_OUTPUT_PIN_O == $past(CMP_OUT_I))
    else $error("comparator lost priority");
  // R18 duty only at underflow while running
  duty_upd_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R18
    timer_ctrl_one_q[`B_COUNT_EN] && !uf |=> $stable(duty_act_q))
    else $error("duty changed mid frame");

  // Low ratio bits of the prescaler, all ones just before a carry
  assign psc_mask = 8'hFF >> (3'd7 - timer_ctrl_two_q[2:0]);

  // Bus request, then a one-cycle answer
  sequence bus_take_s;
    CYC_I && STB_I && !ACK_O;
  endsequence : bus_take_s
  sequence ack_pulse_s;
    ACK_O ##1 !ACK_O;
  endsequence : ack_pulse_s
  sequence read_low_s;
    CYC_I && STB_I && !ACK_O && !WE_I && ADR_I == `ADR_RELOAD_LOW;
  endsequence : read_low_s
  sequence read_psc_s;
    CYC_I && STB_I && !ACK_O && !WE_I && ADR_I == `ADR_PRESC_COUNT;
  endsequence : read_psc_s
  // Underflow that restarts from the buffered value
  sequence reload_uf_s;
    uf && (timer_ctrl_one_q[`B_RELOAD_SEL] || timer_ctrl_one_q[`B_ONE_SHOT]);
  endsequence : reload_uf_s

  // R4 one-cycle acknowledge
  ack_once_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R4
    bus_take_s |=> ack_pulse_s)
    else $error("acknowledge not a single pulse");
  // R4 live low count on read
  read_live_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R4
    read_low_s |=> DAT_O[7:0] == $past(count_q[7:0]))
    else $error("stale count read");
  // R9 prescaler count read back
  read_psc_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R9
    read_psc_s |=> DAT_O[7:0] == $past(prescaler_q))
    else $error("wrong prescaler readback");
  // R2 buffered reload at underflow
  reload_uf_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R2
    reload_uf_s |=> count_q == $past(reload_val))
    else $error("reload not applied");
  // R8 tick only where selected bits carry
  psc_tick_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R8
    !timer_ctrl_two_q[`B_PSC_EN_N] && src_tick
    |-> tick == ((prescaler_q & psc_mask) == psc_mask))
    else $error("wrong prescaler ratio");
  // R7 falling edge when selected
  edge_fall_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R7
    timer_ctrl_two_q[`B_SRC_SEL] && timer_ctrl_two_q[`B_EDGE_SEL] && src_tick
    |-> $past(EXT_COUNT_CLOCK_I) && !EXT_COUNT_CLOCK_I)
    else $error("tick off the falling edge");
  // R7 rising edge when selected
  edge_rise_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R7
    timer_ctrl_two_q[`B_SRC_SEL] && !timer_ctrl_two_q[`B_EDGE_SEL] && src_tick
    |-> !$past(EXT_COUNT_CLOCK_I) && EXT_COUNT_CLOCK_I)
    else $error("tick off the rising edge");
  // R12 enabled underflow raises the request
  irq_req_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R12
    uf && underflow_irq_enable_q && global_irq_enable_q && !wr |=> IRQ_O)
    else $error("no interrupt request");
  // R13 flag stays without a clearing write
  flag_keep_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R13
    underflow_flag_q && !(wr && ADR_I == `ADR_IRQ_FLAG) |=> underflow_flag_q)
    else $error("flag lost");
  // R16 zero duty never active
  duty_zero_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R16
    duty_act_q == 10'h000 |=> pwm_q == $past(timer_ctrl_one_q[`B_PWM_AL]))
    else $error("zero duty went active");
  // R14 PWM owns pin below comparator
  pin_pwm_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R14
    !CMP_OUT_EN_I && timer_ctrl_one_q[`B_PWM_OEN]
    |=> SHARED_OUTPUT_PIN_OE_O && SHARED_OUTPUT_PIN_O == $past(pwm_q))
    else $error("PWM not on pin");
  // R19 tone drives pin when alone
  pin_tone_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R19
    !CMP_OUT_EN_I && !timer_ctrl_one_q[`B_PWM_OEN] && tone_ctrl_reg_q[`B_TONE_EN]
    |=> SHARED_OUTPUT_PIN_OE_O && SHARED_OUTPUT_PIN_O == $past(tone_q))
    else $error("tone not on pin");
  // R22 unclaimed pin released
  pin_free_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R22
    !CMP_OUT_EN_I && !timer_ctrl_one_q[`B_PWM_OEN] && !tone_ctrl_reg_q[`B_TONE_EN]
    |=> !SHARED_OUTPUT_PIN_OE_O && !SHARED_OUTPUT_PIN_O)
    else $error("pin driven with no owner");
  // R20 R23 tone follows a timer bit
  tone_bit_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R20
    tone_ctrl_reg_q[`B_TONE_SRC]
    |=> TONE_OUTPUT_O == $past(count_q[tone_ctrl_reg_q[2:0]]))
    else $error("tone off timer bit");
  // R21 R23 tone follows a prescaler tap
  tone_tap_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // R21
    !tone_ctrl_reg_q[`B_TONE_SRC]
    |=> TONE_OUTPUT_O == $past(prescaler_q[tone_ctrl_reg_q[2:0]]))
    else $error("tone off prescaler tap");
endmodule : down_timer_pwm_buzzer

//--- include/down_timer_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the down timer
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Included by the timer module and the testbench
`ifndef DOWN_TIMER_CFG_SVH
`define DOWN_TIMER_CFG_SVH
`define ADR_CTRL_ONE 6'h00
`define ADR_CTRL_TWO 6'h04
`define ADR_HIGH_BITS 6'h08
`define ADR_RELOAD_LOW 6'h0C
`define ADR_DUTY_LOW 6'h10
`define ADR_TONE_CTRL 6'h14
`define ADR_PRESC_COUNT 6'h18
`define ADR_IRQ_FLAG 6'h1C
`define ADR_IRQ_ENABLE 6'h20
`define ADR_GLOBAL 6'h24
`define B_COUNT_EN 0
`define B_RELOAD_SEL 1
`define B_ONE_SHOT 2
`define B_PWM_AL 6
`define B_PWM_OEN 7
`define B_PSC_EN_N 3
`define B_EDGE_SEL 4
`define B_SRC_SEL 5
`define B_TONE_EN 7
`define B_TONE_SRC 3
`define B_UF_FLAG 3
`define B_GIE 0
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h3F
`define RST_TONE_CTRL 8'h0F
`define TIMER_MAX 10'h3FF
`define INSTR_DIV 8'd2
`endif

//--- include/down_timer_pkg.sv
// Purpose: Types shared by the down timer
// Assumes: Constants come from the cfg header
// Notes: Types only
package down_timer_pkg;
  typedef logic [9:0] count_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {PIN_COMP, PIN_PWM, PIN_TONE, PIN_NONE} pin_src_t;
endpackage : down_timer_pkg

//--- testbench/down_timer_pwm_buzzer_tb.sv
// Purpose: Self-checking bench for the down timer, PWM and tone block
// Assumes: External count clock is slow against CLK_I
// Notes: Directed scenarios, one task each; underflow is the tick taken at zero
`include "down_timer_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); end end
module down_timer_pwm_buzzer_tb import down_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ext_clk = 1'b0, cmp = 1'b0, cmp_en = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic ack, pin, pin_oe, tone, irq, t0;
  int fails = 0, checked = 0;
  byte_t rb, p0;
  count_t c;

  initial forever #4 clk = ~clk;

  down_timer_pwm_buzzer dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .EXT_COUNT_CLOCK_I(ext_clk), .CMP_OUT_I(cmp), .CMP_OUT_EN_I(cmp_en),
    .SHARED_OUTPUT_PIN_O(pin), .SHARED_OUTPUT_PIN_OE_O(pin_oe), .TONE_OUTPUT_O(tone),
    .IRQ_O(irq));

  // Request held until ack is sampled; only the watchdog ends the wait
  task automatic bus(input logic [5:0] a, input logic w, input byte_t d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rb = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input byte_t d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input byte_t e);
    bus(a, 1'b0, 8'h00);
    `CHK(rb, e)
  endtask : rd
  task automatic cnt(output count_t v);
    bus(`ADR_HIGH_BITS, 1'b0, 8'h00);
    v[9:8] = rb[5:4];
    bus(`ADR_RELOAD_LOW, 1'b0, 8'h00);
    v[7:0] = rb;
  endtask : cnt
  task automatic cnt_is(input count_t e);
    cnt(c);
    `CHK(c, e)
  endtask : cnt_is
  // high bits written before the low byte
  task automatic ld(input byte_t h, input byte_t l);
    wr(`ADR_HIGH_BITS, h);
    wr(`ADR_RELOAD_LOW, l);
  endtask : ld
  task automatic ext(input logic v);
    @(posedge clk);
    ext_clk <= v;
    repeat (3) @(posedge clk);
  endtask : ext
  task automatic tick(input int n);
    repeat (n) begin
      ext(1'b1);
      ext(1'b0);
    end
  endtask : tick
  // Pin is registered, so let it settle
  task automatic pin_is(input logic [1:0] e);
    repeat (2) @(posedge clk);
    `CHK({pin_oe, pin}, e)
  endtask : pin_is

  task automatic t_reset;
    rd(`ADR_CTRL_ONE, `RST_CTRL_ONE);
    rd(`ADR_CTRL_TWO, `RST_CTRL_TWO);
    rd(`ADR_TONE_CTRL, `RST_TONE_CTRL);
    rd(6'h28, 8'h00);
    cnt_is(`TIMER_MAX);
    `CHK({pin_oe, irq}, 2'b00)
    ld(8'h10, 8'h23);
    cnt_is(10'h123);
  endtask : t_reset

  task automatic t_clock;
    wr(`ADR_CTRL_TWO, 8'h38);
    ld(8'h00, 8'h40);
    tick(2);
    cnt_is(10'h040);
    wr(`ADR_CTRL_ONE, 8'h01);
    tick(2);
    cnt_is(10'h03E);
    ext(1'b1);
    cnt_is(10'h03E);
    ext(1'b0);
    cnt_is(10'h03D);
    wr(`ADR_CTRL_TWO, 8'h28);
    ext(1'b1);
    cnt_is(10'h03C);
    ext(1'b0);
    wr(`ADR_CTRL_TWO, 8'h30);
    bus(`ADR_PRESC_COUNT, 1'b0, 8'h00);
    p0 = rb;
    tick(1);
    bus(`ADR_PRESC_COUNT, 1'b0, 8'h00);
    `CHK(rb != p0, 1'b1)
    tick(1);
    cnt_is(10'h03B);
    wr(`ADR_CTRL_TWO, 8'h37);
    tick(256);
    cnt_is(10'h03A);
    wr(`ADR_CTRL_TWO, 8'h08);
    repeat (40) @(posedge clk);
    wr(`ADR_CTRL_ONE, 8'h00);
    cnt(c);
    `CHK(c < 10'h03A, 1'b1)
    wr(`ADR_CTRL_TWO, 8'h38);
  endtask : t_clock

  task automatic t_irq;
    wr(`ADR_IRQ_ENABLE, 8'h08);
    ld(8'h00, 8'h03);
    wr(`ADR_CTRL_ONE, 8'h05);
    tick(4);
    rd(`ADR_IRQ_FLAG, 8'h08);
    `CHK(irq, 1'b0)
    rd(`ADR_CTRL_ONE, 8'h04);
    tick(2);
    cnt_is(10'h003);
    wr(`ADR_GLOBAL, 8'h01);
    `CHK(irq, 1'b1)
    rd(`ADR_IRQ_FLAG, 8'h08);
    wr(`ADR_IRQ_FLAG, 8'h00);
    `CHK(irq, 1'b0)
  endtask : t_irq

  task automatic t_free;
    wr(`ADR_CTRL_ONE, 8'h01);
    tick(5);
    cnt_is(10'h3FE);
    wr(`ADR_CTRL_ONE, 8'h00);
    ld(8'h00, 8'h02);
    wr(`ADR_CTRL_ONE, 8'h03);
    tick(1);
    wr(`ADR_RELOAD_LOW, 8'h05);
    cnt_is(10'h001);
    tick(2);
    cnt_is(10'h005);
    wr(`ADR_CTRL_ONE, 8'h00);
    wr(`ADR_IRQ_FLAG, 8'h00);
  endtask : t_free

  task automatic t_pwm;
    // duty kept at or below reload
    ld(8'h00, 8'h04);
    wr(`ADR_DUTY_LOW, 8'h02);
    wr(`ADR_CTRL_ONE, 8'h83);
    pin_is(2'b10);
    tick(3);
    pin_is(2'b11);
    wr(`ADR_DUTY_LOW, 8'h00);
    tick(1);
    pin_is(2'b11);
    tick(4);
    pin_is(2'b10);
    wr(`ADR_CTRL_ONE, 8'hC3);
    pin_is(2'b11);
  endtask : t_pwm

  task automatic t_pin;
    wr(`ADR_TONE_CTRL, 8'h88);
    tick(1);
    pin_is(2'b11);
    `CHK(tone, 1'b0)
    @(posedge clk);
    cmp_en <= 1'b1;
    pin_is(2'b10);
    cmp_en <= 1'b0;
    wr(`ADR_CTRL_ONE, 8'h01);
    pin_is(2'b10);
    tick(1);
    pin_is(2'b11);
    wr(`ADR_CTRL_TWO, 8'h30);
    wr(`ADR_TONE_CTRL, 8'h80);
    @(posedge clk);
    t0 = tone;
    tick(1);
    `CHK(tone, ~t0)
    wr(`ADR_TONE_CTRL, 8'h00);
    pin_is(2'b00);
  endtask : t_pin

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs some 2.6k cycles; this leaves ample margin
  initial begin
    #400us;
    fails++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_clock;
    t_irq;
    t_free;
    t_pwm;
    t_pin;
    report_and_stop;
  end
endmodule : down_timer_pwm_buzzer_tb
